// *** pkg/smd_pkg.sv ***
// shared constants, carriers and states for the spi master dma block
`default_nettype none
package smd_pkg;
	localparam int ADR_W = 12;
	localparam int HALF_W = 10;
	localparam int LIST_W = 2;
	localparam logic [ADR_W-1:0] OFF_START = 12'h010;
	localparam logic [ADR_W-1:0] OFF_STOP = 12'h014;
	localparam logic [ADR_W-1:0] OFF_SUSPEND = 12'h01C;
	localparam logic [ADR_W-1:0] OFF_RESUME = 12'h020;
	localparam logic [ADR_W-1:0] OFF_LINKS = 12'h200;
	localparam logic [ADR_W-1:0] OFF_IRQ_SET = 12'h304;
	localparam logic [ADR_W-1:0] OFF_IRQ_CLR = 12'h308;
	localparam logic [ADR_W-1:0] OFF_ENABLE = 12'h500;
	localparam logic [ADR_W-1:0] OFF_PSEL_SCK = 12'h508;
	localparam logic [ADR_W-1:0] OFF_PSEL_DOUT = 12'h50C;
	localparam logic [ADR_W-1:0] OFF_PSEL_DIN = 12'h510;
	localparam logic [ADR_W-1:0] OFF_RATE = 12'h524;
	localparam logic [ADR_W-1:0] OFF_RX_PTR = 12'h534;
	localparam logic [ADR_W-1:0] OFF_RX_LIMIT = 12'h538;
	localparam logic [ADR_W-1:0] OFF_RX_DONE = 12'h53C;
	localparam logic [ADR_W-1:0] OFF_RX_LIST = 12'h540;
	localparam logic [ADR_W-1:0] OFF_TX_PTR = 12'h544;
	localparam logic [ADR_W-1:0] OFF_TX_LIMIT = 12'h548;
	localparam logic [ADR_W-1:0] OFF_TX_DONE = 12'h54C;
	localparam logic [ADR_W-1:0] OFF_TX_LIST = 12'h550;
	localparam logic [ADR_W-1:0] OFF_CONFIG = 12'h554;
	localparam logic [ADR_W-1:0] OFF_FILL = 12'h5C0;
	// event index: stopped, rx done, both done, tx done, started
	localparam int EV_NUM = 5;
	localparam int EV_STOPPED = 0;
	localparam int EV_RXDONE = 1;
	localparam int EV_END = 2;
	localparam int EV_TXDONE = 3;
	localparam int EV_STARTED = 4;
	localparam logic [ADR_W-1:0] EV_OFFS [EV_NUM] = '{12'h104, 12'h110,
		12'h118, 12'h120, 12'h14C};
	localparam logic [31:0] PSEL_RST = 32'hFFFFFFFF;
	localparam logic [31:0] RATE_RST = 32'h04000000;
	localparam logic [31:0] IRQ_MASK = 32'h00080152;
	localparam logic [3:0] ENABLE_ON = 4'h7;
	localparam int PSEL_CONNECT_BIT = 31;
	localparam int RATE_LOW_BIT = 25;
	localparam int RATE_STEPS = 7;
	localparam int CLK_HZ = 200000000;
	localparam int RATE_BASE_BPS = 125000;
	localparam int HALF_BASE = CLK_HZ / (2 * RATE_BASE_BPS);
	localparam logic [3:0] LAST_EDGE = 4'hF;
	typedef struct packed {
		logic cpol;
		logic cpha;
		logic lowFirst;
	} smd_cfg_t;
	typedef struct packed {
		logic req;
		logic [31:0] addr;
		logic [7:0] data;
	} smd_dma_t;
	typedef enum {S_IDLE, S_CHECK, S_FETCH, S_SHIFT, S_STORE, S_SUSP}
		smd_state_t;
endpackage : smd_pkg
`default_nettype wire

// *** rtl/smd_spi_master_dma.sv ***
// spi master moving bytes between ram and the link, wishbone registers
// Overview of operation
// - start task begins transfer, raises started
// - tx done after tx_byte_limit bytes sent
// - rx done after rx_byte_limit bytes stored
// - end event once both done events occurred
// - stop task halts, stopped event at rest, unless the transfer finishes first: then no stopped event
// - halt forces rx done if not yet
// - halt forces tx done if not yet
// - one byte in per byte out
// - pointers and limits double buffered at start
// - clocking ends when both limits reached
// - bytes past tx limit use fill byte
// - bytes past rx limit are discarded
// - reader fetches, writer stores, no processor
// - byte counts of last transfer readable
// - config selects polarity and phase, modes 0-3
// - order 0 high bit first, 1 low
// - phase 0 sample leading, 1 trailing
// - polarity sets active level and idle level
// - one-hot rate code, 125 kbps to 8 Mbps
// - end-to-start link restarts on end of a finished transfer, not after stop
// - enabled only when enable field is 7
`default_nettype none
module smd_spi_master_dma import smd_pkg::*; #(
	parameter int CNT_W = 16
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [ADR_W-1:0] wbAdrI,
	input wire logic [31:0] wbDatI,
	input wire logic [3:0] wbSelI,
	input wire logic wbWeI,
	input wire logic wbCycI,
	input wire logic wbStbI,
	output logic [31:0] wbDatO,
	output logic wbAckO,
	output smd_dma_t rdReq,
	input wire logic rdAck,
	input wire logic [7:0] rdData,
	output smd_dma_t wrReq,
	input wire logic wrAck,
	output logic sckOut,
	output logic sckOe,
	output logic doutOut,
	output logic doutOe,
	input wire logic dinIn,
	output logic [31:0] sckPinSel,
	output logic [31:0] doutPinSel,
	output logic [31:0] dinPinSel
);
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [31:0] m);
		return (old & ~m) | (nw & m);
	endfunction : merge

	function automatic logic bitOf(input logic [7:0] b,
		input logic [2:0] idx, input logic lowFirst);
		return lowFirst ? b[idx] : b[~idx];
	endfunction : bitOf

	logic wbAck_q;
	logic [31:0] wbDat_q;
	logic [31:0] rdMux;
	logic links_q;
	logic [31:0] irqEn_q;
	logic [3:0] enable_q;
	logic [31:0] pselSck_q;
	logic [31:0] pselDout_q;
	logic [31:0] pselDin_q;
	logic [31:0] rate_q;
	logic [31:0] rxPtr_q;
	logic [31:0] txPtr_q;
	logic [CNT_W-1:0] rxLim_q;
	logic [CNT_W-1:0] txLim_q;
	logic [LIST_W-1:0] rxList_q;
	logic [LIST_W-1:0] txList_q;
	smd_cfg_t cfg_q;
	logic [7:0] fill_q;
	logic [EV_NUM-1:0] ev_q;
	logic [EV_NUM-1:0] evSet;
	logic [EV_NUM-1:0] evWr;
	smd_state_t state_q;
	smd_state_t state_d;
	logic [CNT_W-1:0] txCnt_q;
	logic [CNT_W-1:0] rxCnt_q;
	logic [CNT_W-1:0] txLimA_q;
	logic [CNT_W-1:0] rxLimA_q;
	logic [31:0] txPtrA_q;
	logic [31:0] rxPtrA_q;
	logic txSeen_q;
	logic rxSeen_q;
	logic stopReq_q;
	logic suspReq_q;
	logic shortStart_q;
	logic [7:0] txByte_q;
	logic [7:0] rxSh_q;
	logic [HALF_W-1:0] half_q;
	logic [HALF_W-1:0] halfLoad;
	logic [3:0] edge_q;
	logic sck_q;
	logic dout_q;
	logic dinMeta_q;
	logic dinSync_q;
	smd_dma_t rd_q;
	smd_dma_t wr_q;

	// bus slave: one wait state, unmapped reads return zero
	wire logic busHit = wbCycI && wbStbI && !wbAck_q;
	// writes land on the edge at which the master sees ack high
	wire logic wrStb = wbCycI && wbStbI && wbAck_q && wbWeI;
	wire logic [31:0] wMask = {{8{wbSelI[3]}}, {8{wbSelI[2]}},
		{8{wbSelI[1]}}, {8{wbSelI[0]}}};
	wire logic bit0W = wbSelI[0] && wbDatI[0];
	wire logic low0 = wrStb && wbSelI[0];
	wire logic trigStart = wrStb && wbAdrI == OFF_START && bit0W;
	wire logic trigStop = wrStb && wbAdrI == OFF_STOP && bit0W;
	wire logic trigSusp = wrStb && wbAdrI == OFF_SUSPEND && bit0W;
	wire logic trigResume = wrStb && wbAdrI == OFF_RESUME && bit0W;
	wire logic wrLinks = low0 && wbAdrI == OFF_LINKS;
	wire logic wrIrqSet = wrStb && wbAdrI == OFF_IRQ_SET;
	wire logic wrIrqClr = wrStb && wbAdrI == OFF_IRQ_CLR;
	wire logic wrEnable = low0 && wbAdrI == OFF_ENABLE;
	wire logic wrPselSck = wrStb && wbAdrI == OFF_PSEL_SCK;
	wire logic wrPselDout = wrStb && wbAdrI == OFF_PSEL_DOUT;
	wire logic wrPselDin = wrStb && wbAdrI == OFF_PSEL_DIN;
	wire logic wrRate = wrStb && wbAdrI == OFF_RATE;
	wire logic wrRxPtr = wrStb && wbAdrI == OFF_RX_PTR;
	wire logic wrRxLim = wrStb && wbAdrI == OFF_RX_LIMIT;
	wire logic wrRxList = low0 && wbAdrI == OFF_RX_LIST;
	wire logic wrTxPtr = wrStb && wbAdrI == OFF_TX_PTR;
	wire logic wrTxLim = wrStb && wbAdrI == OFF_TX_LIMIT;
	wire logic wrTxList = low0 && wbAdrI == OFF_TX_LIST;
	wire logic wrConfig = low0 && wbAdrI == OFF_CONFIG;
	wire logic wrFill = low0 && wbAdrI == OFF_FILL;
	wire logic [31:0] irqBits = wbDatI & wMask & IRQ_MASK;

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			links_q <= 1'b0;
			irqEn_q <= '0;
			enable_q <= '0;
			pselSck_q <= PSEL_RST;
			pselDout_q <= PSEL_RST;
			pselDin_q <= PSEL_RST;
			rate_q <= RATE_RST;
			rxPtr_q <= '0;
			txPtr_q <= '0;
			rxLim_q <= '0;
			txLim_q <= '0;
			rxList_q <= '0;
			txList_q <= '0;
			cfg_q <= '0;
			fill_q <= '0;
		end else begin
			if (wrLinks) links_q <= wbDatI[0];
			if (wrIrqSet) irqEn_q <= irqEn_q | irqBits;
			else if (wrIrqClr) irqEn_q <= irqEn_q & ~irqBits;
			if (wrEnable) enable_q <= wbDatI[3:0];
			if (wrPselSck) pselSck_q <= merge(pselSck_q, wbDatI, wMask);
			if (wrPselDout) pselDout_q <= merge(pselDout_q, wbDatI, wMask);
			if (wrPselDin) pselDin_q <= merge(pselDin_q, wbDatI, wMask);
			if (wrRate) rate_q <= merge(rate_q, wbDatI, wMask);
			if (wrRxPtr) rxPtr_q <= merge(rxPtr_q, wbDatI, wMask);
			if (wrTxPtr) txPtr_q <= merge(txPtr_q, wbDatI, wMask);
			if (wrRxLim) rxLim_q <= CNT_W'(merge(32'(rxLim_q), wbDatI, wMask));
			if (wrTxLim) txLim_q <= CNT_W'(merge(32'(txLim_q), wbDatI, wMask));
			if (wrRxList) rxList_q <= wbDatI[LIST_W-1:0];
			if (wrTxList) txList_q <= wbDatI[LIST_W-1:0];
			if (wrConfig) cfg_q <= wbDatI[2:0];
			if (wrFill) fill_q <= wbDatI[7:0];
		end
	end

	always_comb begin
		rdMux = '0;
		case (wbAdrI)
			OFF_LINKS: rdMux = 32'(links_q);
			OFF_IRQ_SET, OFF_IRQ_CLR: rdMux = irqEn_q;
			OFF_ENABLE: rdMux = 32'(enable_q);
			OFF_PSEL_SCK: rdMux = pselSck_q;
			OFF_PSEL_DOUT: rdMux = pselDout_q;
			OFF_PSEL_DIN: rdMux = pselDin_q;
			OFF_RATE: rdMux = rate_q;
			OFF_RX_PTR: rdMux = rxPtr_q;
			OFF_RX_LIMIT: rdMux = 32'(rxLim_q);
			OFF_RX_DONE: rdMux = 32'(rxCnt_q);
			OFF_RX_LIST: rdMux = 32'(rxList_q);
			OFF_TX_PTR: rdMux = txPtr_q;
			OFF_TX_LIMIT: rdMux = 32'(txLim_q);
			OFF_TX_DONE: rdMux = 32'(txCnt_q);
			OFF_TX_LIST: rdMux = 32'(txList_q);
			OFF_CONFIG: rdMux = 32'(cfg_q);
			OFF_FILL: rdMux = 32'(fill_q);
			default: rdMux = '0;
		endcase
		for (int i = 0; i < EV_NUM; i++) begin
			if (wbAdrI == EV_OFFS[i]) rdMux = 32'(ev_q[i]);
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wbAck_q <= 1'b0;
			wbDat_q <= '0;
		end else begin
			wbAck_q <= busHit;
			if (busHit && !wbWeI) wbDat_q <= rdMux;
		end
	end

	assign wbAckO = wbAck_q;
	assign wbDatO = wbDat_q;

	// events: a hardware set in the cycle of a software write wins
	genvar g;
	generate
		for (g = 0; g < EV_NUM; g++) begin : g_ev
			assign evWr[g] = low0 && wbAdrI == EV_OFFS[g];
			always_ff @(posedge clock or posedge sys_rst) begin
				if (sys_rst) ev_q[g] <= 1'b0;
				else ev_q[g] <= evSet[g] | (evWr[g] ? wbDatI[0] : ev_q[g]);
			end
		end
	endgenerate

	// rate decode; half periods round up so sck never beats its minimum
	always_comb begin
		halfLoad = HALF_W'(HALF_BASE);
		for (int k = 0; k < RATE_STEPS; k++) begin
			if (rate_q[RATE_LOW_BIT + k]) begin
				halfLoad = HALF_W'((HALF_BASE + (1 << k) - 1) >> k);
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			dinMeta_q <= 1'b0;
			dinSync_q <= 1'b0;
		end else begin
			dinMeta_q <= dinIn;
			dinSync_q <= dinMeta_q;
		end
	end

	wire logic enabled = enable_q == ENABLE_ON;
	wire logic txLeft = txCnt_q < txLimA_q;
	wire logic rxLeft = rxCnt_q < rxLimA_q;
	wire logic startReq = trigStart || shortStart_q;
	wire logic startGo = enabled && startReq && state_q == S_IDLE;
	wire logic stopAny = trigStop || stopReq_q;
	wire logic atBound = state_q == S_CHECK;
	wire logic finish = atBound && !txLeft && !rxLeft;
	wire logic haltNow = ((atBound && !finish) || state_q == S_SUSP)
		&& stopAny;
	wire logic pTxDone = !txSeen_q && ((atBound && !txLeft) || haltNow);
	wire logic pRxDone = !rxSeen_q && ((atBound && !rxLeft) || haltNow);
	wire logic pStopped = haltNow || (trigStop && state_q == S_IDLE);
	assign evSet[EV_STOPPED] = pStopped;
	assign evSet[EV_RXDONE] = pRxDone;
	assign evSet[EV_END] = finish || haltNow;
	assign evSet[EV_TXDONE] = pTxDone;
	assign evSet[EV_STARTED] = startGo;

	// sck edge bookkeeping: even edges lead, odd edges trail
	wire logic halfTick = state_q == S_SHIFT && half_q == '0;
	wire logic leadEdge = !edge_q[0];
	wire logic sampleEdge = halfTick && (leadEdge != cfg_q.cpha);
	wire logic shiftEdge = halfTick && (leadEdge == cfg_q.cpha);
	wire logic byteDone = halfTick && edge_q == LAST_EDGE;
	wire logic [4:0] outSum = {1'b0, edge_q} + {4'h0, !cfg_q.cpha};
	wire logic enterShift = state_d == S_SHIFT && state_q != S_SHIFT;
	wire logic enterFetch = state_d == S_FETCH && state_q != S_FETCH;
	wire logic enterStore = state_d == S_STORE && state_q != S_STORE;
	wire logic [7:0] nextByte = state_q == S_FETCH ? rdData : fill_q;
	wire logic [7:0] rxNext = cfg_q.lowFirst ? {dinSync_q, rxSh_q[7:1]}
		: {rxSh_q[6:0], dinSync_q};

	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE: if (startGo) state_d = S_CHECK;
			S_CHECK: begin
				if (finish || haltNow) state_d = S_IDLE;
				else if (suspReq_q || trigSusp) state_d = S_SUSP;
				else if (txLeft) state_d = S_FETCH;
				else state_d = S_SHIFT;
			end
			S_FETCH: if (rdAck) state_d = S_SHIFT;
			S_SHIFT: begin
				if (byteDone) state_d = rxLeft ? S_STORE : S_CHECK;
			end
			S_STORE: if (wrAck) state_d = S_CHECK;
			S_SUSP: begin
				if (haltNow) state_d = S_IDLE;
				else if (trigResume) state_d = S_CHECK;
			end
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= S_IDLE;
			shortStart_q <= 1'b0;
			stopReq_q <= 1'b0;
			suspReq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			shortStart_q <= finish && links_q;
			if (state_d == S_IDLE) stopReq_q <= 1'b0;
			else if (trigStop) stopReq_q <= 1'b1;
			if (state_d == S_IDLE || state_d == S_SUSP) suspReq_q <= 1'b0;
			else if (trigSusp) suspReq_q <= 1'b1;
		end
	end

	// active copies let software prepare the next transfer meanwhile
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			txPtrA_q <= '0;
			rxPtrA_q <= '0;
			txLimA_q <= '0;
			rxLimA_q <= '0;
		end else if (startGo) begin
			txPtrA_q <= txPtr_q;
			rxPtrA_q <= rxPtr_q;
			txLimA_q <= txLim_q;
			rxLimA_q <= rxLim_q;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			txCnt_q <= '0;
			rxCnt_q <= '0;
			txSeen_q <= 1'b0;
			rxSeen_q <= 1'b0;
		end else if (startGo) begin
			txCnt_q <= '0;
			rxCnt_q <= '0;
			txSeen_q <= 1'b0;
			rxSeen_q <= 1'b0;
		end else begin
			if (state_q == S_FETCH && rdAck) txCnt_q <= txCnt_q + 1'b1;
			if (state_q == S_STORE && wrAck) rxCnt_q <= rxCnt_q + 1'b1;
			if (pTxDone) txSeen_q <= 1'b1;
			if (pRxDone) rxSeen_q <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_q <= '0;
			wr_q <= '0;
		end else begin
			if (enterFetch) begin
				rd_q.req <= 1'b1;
				rd_q.addr <= txPtrA_q + 32'(txCnt_q);
			end else if (rdAck) rd_q.req <= 1'b0;
			if (enterStore) begin
				wr_q.req <= 1'b1;
				wr_q.addr <= rxPtrA_q + 32'(rxCnt_q);
				wr_q.data <= sampleEdge ? rxNext : rxSh_q;
			end else if (wrAck) wr_q.req <= 1'b0;
		end
	end

	// din is two cycles late, fine while a half period is three or more
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			txByte_q <= '0;
			rxSh_q <= '0;
			half_q <= '0;
			edge_q <= '0;
			sck_q <= 1'b0;
			dout_q <= 1'b0;
		end else if (enterShift) begin
			txByte_q <= nextByte;
			half_q <= halfLoad - 1'b1;
			edge_q <= '0;
			if (!cfg_q.cpha) dout_q <= bitOf(nextByte, 3'h0, cfg_q.lowFirst);
		end else if (state_q == S_SHIFT) begin
			half_q <= halfTick ? halfLoad - 1'b1 : half_q - 1'b1;
			if (halfTick) edge_q <= edge_q + 1'b1;
			if (halfTick) sck_q <= ~sck_q;
			if (sampleEdge) rxSh_q <= rxNext;
			if (shiftEdge && !outSum[4]) begin
				dout_q <= bitOf(txByte_q, outSum[3:1], cfg_q.lowFirst);
			end
		end else begin
			sck_q <= cfg_q.cpol;
		end
	end

	assign rdReq = rd_q;
	assign wrReq = wr_q;
	assign sckOut = sck_q;
	assign doutOut = dout_q;
	assign sckOe = enabled && !pselSck_q[PSEL_CONNECT_BIT];
	assign doutOe = enabled && !pselDout_q[PSEL_CONNECT_BIT];
	assign sckPinSel = pselSck_q;
	assign doutPinSel = pselDout_q;
	assign dinPinSel = pselDin_q;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	started_evt_a: assert property (startGo |=> ev_q[EV_STARTED])
		else $error("started event missing");
	tx_fetch_a: assert property (rd_q.req |-> txCnt_q < txLimA_q)
		else $error("fetch beyond tx limit");
	end_pair_a: assert property ((finish || haltNow)
		|=> txSeen_q && rxSeen_q && ev_q[EV_END])
		else $error("end without both done events");
	stop_rest_a: assert property (haltNow
		|=> state_q == S_IDLE && ev_q[EV_STOPPED] && !rd_q.req)
		else $error("stop did not come to rest");
	halt_done_a: assert property (haltNow && !rxSeen_q
		|=> ev_q[EV_RXDONE] && ev_q[EV_TXDONE])
		else $error("halt did not force done events");
	byte_len_a: assert property ((state_q == S_SHIFT
		&& state_d != S_SHIFT) |-> edge_q == LAST_EDGE && sck_q != cfg_q.cpol)
		else $error("byte ended off its last edge");
	dbl_buf_a: assert property (startGo |=> txLimA_q == $past(txLim_q)
		&& rxPtrA_q == $past(rxPtr_q))
		else $error("active copy not taken at start");
	fill_byte_a: assert property ((enterShift && state_q == S_CHECK)
		|=> txByte_q == fill_q)
		else $error("fill byte not sent");
	discard_a: assert property (wr_q.req |-> rxCnt_q < rxLimA_q)
		else $error("store beyond rx limit");
	sck_idle_a: assert property ((state_q != S_SHIFT
		&& $past(state_q) != S_SHIFT && $stable(cfg_q)) |-> sck_q == cfg_q.cpol)
		else $error("sck idle level wrong");
	rate_slow_a: assert property ((enterShift && rate_q == RATE_RST)
		|=> half_q == HALF_W'(HALF_BASE / 2 - 1))
		else $error("default rate half period wrong");
	enable_a: assert property (!enabled |-> !sckOe && !doutOe)
		else $error("pins driven while disabled");
	susp_hold_a: assert property ((state_q == S_SUSP
		&& $past(state_q) == S_SUSP) |-> $stable(txCnt_q) && !wr_q.req)
		else $error("suspended transfer moved");

	chain_c: cover property (finish && links_q ##1 startGo);
	stop_c: cover property (haltNow && txLeft);
	resume_c: cover property (state_q == S_SUSP ##1 state_q == S_CHECK);
	fill_c: cover property (enterShift && state_q == S_CHECK);
endmodule : smd_spi_master_dma
`default_nettype wire

// *** tb/smd_slave_model.sv ***
// behavioural serial slave that answers the spi master dma block
`default_nettype none
module smd_slave_model import smd_pkg::*; (
	input wire logic sck,
	input wire logic dout,
	input wire logic clr,
	input wire smd_cfg_t cfg,
	output logic din
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got [0:7];
	logic [7:0] shiftIn;
	logic [7:0] outByte;
	logic lastSck;
	int bitCnt;
	int byteCnt;
	function automatic int pos(input int i);
		return cfg.lowFirst ? i : 7 - i;
	endfunction : pos
	// always selected: there is no select line on this link
	always @(sck or clr) begin
		if (clr) begin
			bitCnt = 0;
			byteCnt = 0;
			outByte = 8'h96;
			din = outByte[pos(0)];
			lastSck = sck;
		end else if (sck !== lastSck) begin
			lastSck = sck;
			// sampling edge: leading for phase 0, trailing for phase 1
			if ((sck != cfg.cpol) != cfg.cpha) begin
				shiftIn[pos(bitCnt)] = dout;
				bitCnt++;
				if (bitCnt == 8) begin
					// one reply byte leaves for each byte taken
					got[byteCnt[2:0]] = shiftIn;
					byteCnt++;
					bitCnt = 0;
					outByte = 8'h96 ^ byteCnt[7:0];
				end
			end else begin
				din = outByte[pos(bitCnt)];
			end
		end
	end
endmodule : smd_slave_model
`default_nettype wire

// *** tb/spi_master_dma_bench.sv ***
// self-checking bench for the spi master dma block
`default_nettype none
module spi_master_dma_bench import smd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [ADR_W-1:0] wbAdrI = '0;
	logic [31:0] wbDatI = '0;
	logic [3:0] wbSelI = '0;
	logic wbWeI = 1'b0;
	logic wbCycI = 1'b0;
	logic wbStbI = 1'b0;
	logic [31:0] wbDatO;
	logic wbAckO;
	smd_dma_t rdReq;
	smd_dma_t wrReq;
	logic rdAck = 1'b0;
	logic wrAck = 1'b0;
	logic [7:0] rdData = 8'h00;
	logic sckOut;
	logic sckOe;
	logic doutOut;
	logic doutOe;
	logic dinIn;
	logic slvClr = 1'b1;
	smd_cfg_t slvCfg = '0;
	logic prevSck = 1'b0;
	logic [7:0] mem [0:255];
	int halfMin = 100000;
	int halfRun = 0;
	int fail_count = 0;
	int compares = 0;
	always #2.5 clock = ~clock;
	// memory answers each request one cycle later
	always @(posedge clock) begin
		rdAck <= rdReq.req && !rdAck;
		rdData <= mem[rdReq.addr[7:0]];
		wrAck <= wrReq.req && !wrAck;
		if (wrReq.req && !wrAck)
			mem[wrReq.addr[7:0]] <= wrReq.data;
	end
	// shortest level of the serial clock, in system cycles
	always @(posedge clock) begin
		prevSck <= sckOut;
		if (sckOut !== prevSck) begin
			if (halfRun < halfMin)
				halfMin <= halfRun;
			halfRun <= 1;
		end else
			halfRun <= halfRun + 1;
	end
	smd_spi_master_dma i_smd_spi_master_dma (.clock(clock), .sys_rst(sys_rst),
		.wbAdrI(wbAdrI), .wbDatI(wbDatI), .wbSelI(wbSelI), .wbWeI(wbWeI),
		.wbCycI(wbCycI), .wbStbI(wbStbI), .wbDatO(wbDatO), .wbAckO(wbAckO),
		.rdReq(rdReq), .rdAck(rdAck), .rdData(rdData), .wrReq(wrReq),
		.wrAck(wrAck), .sckOut(sckOut), .sckOe(sckOe), .doutOut(doutOut),
		.doutOe(doutOe), .dinIn(dinIn), .sckPinSel(), .doutPinSel(),
		.dinPinSel());
	smd_slave_model i_smd_slave_model (.sck(sckOut), .dout(doutOut),
		.clr(slvClr), .cfg(slvCfg), .din(dinIn));
	task automatic tally_and_finish;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wb(input logic we, input logic [ADR_W-1:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock);
		wbCycI <= 1'b1;
		wbStbI <= 1'b1;
		wbWeI <= we;
		wbAdrI <= a;
		wbDatI <= d;
		wbSelI <= 4'hF;
		do begin
			@(posedge clock);
			n++;
		end while (wbAckO !== 1'b1 && n < 64);
		q = wbDatO;
		wbCycI <= 1'b0;
		wbStbI <= 1'b0;
		wbWeI <= 1'b0;
		if (n >= 64)
			check({31'h0, wbAckO}, 32'h1);
	endtask : wb
	task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic rc(input logic [ADR_W-1:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		check(q, e);
	endtask : rc
	task automatic waitEv(input int i);
		logic [31:0] q;
		int n;
		n = 0;
		q = '0;
		while (q[0] !== 1'b1 && n < 4000) begin
			wb(1'b0, EV_OFFS[i], 32'h0, q);
			n++;
		end
		check(q, 32'h1);
	endtask : waitEv
	task automatic prep(input logic [2:0] c, input logic [31:0] rate,
		input int ntx, input int nrx, input logic [7:0] fill);
		slvCfg = '{c[2], c[1], c[0]};
		slvClr = 1'b1;
		wr(OFF_CONFIG, {29'h0, c});
		wr(OFF_RATE, rate);
		wr(OFF_FILL, {24'h0, fill});
		for (int i = 0; i < 8; i++) begin
			mem[8'h20 + i] = 8'h3A + 8'(i * 17) + {5'h0, c};
			mem[8'h80 + i] = 8'hEE;
		end
		wr(OFF_TX_PTR, 32'h20);
		wr(OFF_TX_LIMIT, 32'(ntx));
		wr(OFF_RX_PTR, 32'h80);
		wr(OFF_RX_LIMIT, 32'(nrx));
		for (int i = 0; i < EV_NUM; i++)
			wr(EV_OFFS[i], 32'h0);
		slvClr = 1'b0;
		halfMin = 100000;
	endtask : prep
	task automatic xfer(input logic [2:0] c, input logic [31:0] rate,
		input int ntx, input int nrx, input logic [7:0] fill, input int half);
		prep(c, rate, ntx, nrx, fill);
		wr(OFF_START, 32'h1);
		waitEv(EV_END);
		rc(EV_OFFS[EV_TXDONE], 32'h1);
		rc(EV_OFFS[EV_RXDONE], 32'h1);
		rc(EV_OFFS[EV_STARTED], 32'h1);
		rc(OFF_TX_DONE, 32'(ntx));
		rc(OFF_RX_DONE, 32'(nrx));
		for (int i = 0; i < ntx || i < nrx; i++)
			check(i_smd_slave_model.got[i], (i < ntx) ? mem[8'h20 + i] : fill);
		for (int i = 0; i < nrx; i++)
			check(mem[8'h80 + i], 8'h96 ^ 8'(i));
		check(mem[8'h80 + nrx], 8'hEE);
		check(sckOut, c[2]);
		check(halfMin, half);
	endtask : xfer
	initial begin
		#400000;
		fail_count++;
		tally_and_finish;
	end
	initial begin
		logic [31:0] q;
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		rc(OFF_PSEL_SCK, PSEL_RST);
		rc(OFF_RATE, RATE_RST);
		rc(OFF_CONFIG, 32'h0);
		rc(12'h7FC, 32'h0);
		wr(OFF_TX_DONE, 32'h5);
		rc(OFF_TX_DONE, 32'h0);
		// pins are chosen while the block is still off
		wr(OFF_PSEL_SCK, 32'h3);
		wr(OFF_PSEL_DOUT, 32'h4);
		wr(OFF_PSEL_DIN, 32'h5);
		check(sckOe, 1'b0);
		wr(OFF_START, 32'h1);
		repeat (20) @(posedge clock);
		rc(EV_OFFS[EV_STARTED], 32'h0);
		wr(OFF_ENABLE, 32'h7);
		@(posedge clock);
		check({sckOe, doutOe}, 2'h3);
		for (int c = 0; c < 8; c++)
			xfer(3'(c), 32'h80000000, 2, 2, 8'h00, 13);
		xfer(3'h0, 32'h20000000, 1, 1, 8'h00, 50);
		xfer(3'h0, RATE_RST, 1, 1, 8'h00, 400);
		xfer(3'h5, 32'h80000000, 1, 3, 8'h5A, 13);
		xfer(3'h2, 32'h80000000, 3, 1, 8'h00, 13);
		// the restarted transfer must use the pointer written after started
		wr(OFF_LINKS, 32'h1);
		prep(3'h0, 32'h80000000, 1, 1, 8'h00);
		mem[8'h28] = 8'hC3;
		wr(OFF_START, 32'h1);
		waitEv(EV_STARTED);
		wr(OFF_TX_PTR, 32'h28);
		waitEv(EV_END);
		// drop the link first so the restarted transfer is the last one
		wr(OFF_LINKS, 32'h0);
		wr(EV_OFFS[EV_END], 32'h0);
		waitEv(EV_END);
		check(i_smd_slave_model.got[0], mem[8'h20]);
		check(i_smd_slave_model.got[1], mem[8'h28]);
		prep(3'h0, 32'h80000000, 6, 6, 8'h00);
		wr(OFF_START, 32'h1);
		repeat (300) @(posedge clock);
		wr(OFF_SUSPEND, 32'h1);
		repeat (600) @(posedge clock);
		wb(1'b0, OFF_TX_DONE, 32'h0, q);
		repeat (600) @(posedge clock);
		rc(OFF_TX_DONE, q);
		wr(OFF_RESUME, 32'h1);
		repeat (100) @(posedge clock);
		rc(OFF_TX_DONE, q + 32'h1);
		wr(OFF_STOP, 32'h1);
		waitEv(EV_STOPPED);
		rc(EV_OFFS[EV_TXDONE], 32'h1);
		rc(EV_OFFS[EV_RXDONE], 32'h1);
		wb(1'b0, OFF_TX_DONE, 32'h0, q);
		check({31'h0, q < 32'd6}, 32'h1);
		wr(OFF_ENABLE, 32'h0);
		@(posedge clock);
		check(sckOe, 1'b0);
		tally_and_finish;
	end
endmodule : spi_master_dma_bench
`default_nettype wire
